/* File: rtl/video_frame_params.svh */
// Purpose: Constants for the video stream frame control block
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef VIDEO_FRAME_PARAMS_SVH
`define VIDEO_FRAME_PARAMS_SVH

// Default build values
`define VFC_DATA_WIDTH 24
`define VFC_DIM_WIDTH 12
`define VFC_DEF_WIDTH 1920
`define VFC_DEF_HEIGHT 1080
`define VFC_HAS_CTRL 1

// Least hardware reset hold, in clock cycles
`define VFC_RESET_HOLD_CYCLES 32

`endif

/* File: rtl/video_frame_pkg.sv */
// Purpose: Types for the video stream frame control block
// Assumes: Nothing
// Notes: State codes are Gray along idle, active, drop line, drop frame
`default_nettype none
package video_frame_pkg;

  typedef enum logic [1:0]
  {
    st_idle = 2'h0,
    st_active = 2'h1,
    st_drop_line = 2'h3,
    st_drop_frame = 2'h2
  } frame_state_type;

endpackage
`default_nettype wire

/* File: rtl/video_stream_frame_control.sv */
// Purpose: Frame and line tracking with early and late marker recovery
// Assumes: One clock; stream inputs synchronous to clk
// Notes: One output slot; input accepted only while the slot is empty
`include "video_frame_params.svh"
`timescale 1ns/1ps
`default_nettype none

module video_stream_frame_control #(
  parameter int DATA_WIDTH = `VFC_DATA_WIDTH,
  parameter int DIM_WIDTH = `VFC_DIM_WIDTH,
  parameter int DEF_WIDTH = `VFC_DEF_WIDTH,
  parameter int DEF_HEIGHT = `VFC_DEF_HEIGHT,
  parameter bit HAS_CTRL = `VFC_HAS_CTRL
)
(
  // Clock, enable and reset
  input wire logic clk,
  input wire logic aclken,
  input wire logic rst_n,
  // Control
  input wire logic sw_enable,
  input wire logic sw_reset,
  input wire logic [DIM_WIDTH-1:0] cfg_width,
  input wire logic [DIM_WIDTH-1:0] cfg_height,
  // Input stream
  input wire logic s_axis_tvalid,
  output logic s_axis_tready,
  input wire logic [DATA_WIDTH-1:0] s_axis_tdata,
  input wire logic s_axis_tuser,
  input wire logic s_axis_tlast,
  // Output stream
  output logic m_axis_tvalid,
  input wire logic m_axis_tready,
  output logic [DATA_WIDTH-1:0] m_axis_tdata,
  output logic m_axis_tuser,
  output logic m_axis_tlast,
  // Status
  output logic busy,
  output logic frame_done,
  output logic sof_early_err,
  output logic sof_late_err,
  output logic line_end_early_err,
  output logic line_end_late_err
);
  import video_frame_pkg::*;

  typedef struct packed {
    frame_state_type fsm;
    logic [DIM_WIDTH-1:0] x;
    logic [DIM_WIDTH-1:0] y;
    logic s_ready;
    logic m_valid;
    logic [DATA_WIDTH-1:0] m_data;
    logic m_sof;
    logic m_line_end;
    logic busy;
    logic done;
    logic sof_early;
    logic sof_late;
    logic line_end_early;
    logic line_end_late;
  } state_type;

  localparam state_type RESET_STATE = '{fsm: st_idle, s_ready: 1'b1, default: '0};

  if (DATA_WIDTH < 1 || DIM_WIDTH < 2 || DEF_WIDTH < 1 || DEF_HEIGHT < 1
      || DEF_WIDTH >= (1 << DIM_WIDTH) || DEF_HEIGHT >= (1 << DIM_WIDTH))
  begin : bad_params
    $error("video_stream_frame_control: unsupported parameter values");
  end

  state_type st;
  state_type next_st;
  logic go;
  logic acc;
  logic origin;
  logic [DIM_WIDTH-1:0] last_x;
  logic [DIM_WIDTH-1:0] last_y;

  assign last_x = HAS_CTRL ? cfg_width - 1'b1 : DIM_WIDTH'(DEF_WIDTH - 1);
  assign last_y = HAS_CTRL ? cfg_height - 1'b1 : DIM_WIDTH'(DEF_HEIGHT - 1);

  assign go = aclken && sw_enable && !sw_reset;
  assign acc = go && st.s_ready && s_axis_tvalid;
  assign origin = (st.x == '0) && (st.y == '0);

  always_comb
  begin
    logic drop;
    logic restart;
    logic [DIM_WIDTH-1:0] px;
    logic [DIM_WIDTH-1:0] py;
    drop = 1'b1;
    restart = 1'b0;
    px = st.x;
    py = st.y;
    next_st = st;
    if (st.m_valid && m_axis_tready)
    begin
      next_st.m_valid = 1'b0;
    end
    if (acc)
    begin
      case (st.fsm)
        st_active:
        begin
          if (s_axis_tuser && !origin)
          begin
            restart = 1'b1;
            next_st.sof_early = 1'b1;
            drop = 1'b0;
          end
          else if (origin && !s_axis_tuser)
          begin
            next_st.sof_late = 1'b1;
            next_st.fsm = st_drop_frame;
          end
          else
          begin
            drop = 1'b0;
          end
        end
        st_drop_line:
        begin
          if (s_axis_tuser)
          begin
            restart = 1'b1;
            next_st.sof_early = 1'b1;
            drop = 1'b0;
          end
          else if (s_axis_tlast)
          begin
            next_st.fsm = st_active;
          end
        end
        default:
        begin
          if (s_axis_tuser)
          begin
            restart = 1'b1;
            drop = 1'b0;
          end
        end
      endcase
      if (!drop)
      begin
        if (restart)
        begin
          px = '0;
          py = '0;
          next_st.fsm = st_active;
        end
        next_st.m_valid = 1'b1;
        next_st.m_data = s_axis_tdata;
        next_st.m_sof = (px == '0) && (py == '0);
        next_st.m_line_end = (px == last_x) || s_axis_tlast;
        if (next_st.m_sof)
        begin
          next_st.done = 1'b0;
          next_st.busy = 1'b1;
        end
        if (s_axis_tlast && px != last_x)
        begin
          next_st.line_end_early = 1'b1;
        end
        // Late line end at programmed place
        if (px == last_x && !s_axis_tlast)
        begin
          next_st.line_end_late = 1'b1;
          next_st.fsm = st_drop_line;
        end
        if (next_st.m_line_end)
        begin
          next_st.x = '0;
          if (py == last_y)
          begin
            next_st.y = '0;
            next_st.done = 1'b1;
            next_st.busy = 1'b0;
          end
          else
          begin
            next_st.y = py + 1'b1;
          end
        end
        else
        begin
          next_st.x = px + 1'b1;
          next_st.y = py;
        end
      end
    end
    next_st.s_ready = !next_st.m_valid;
  end

  always_ff @(posedge clk)
  begin
    // Reset acts regardless of frame position
    if (!rst_n)
    begin
      st <= RESET_STATE;
    end
    else if (aclken && sw_reset)
    begin
      st <= RESET_STATE;
    end
    else if (aclken && sw_enable)
    begin
      st <= next_st;
    end
  end

  assign s_axis_tready = st.s_ready;
  assign m_axis_tvalid = st.m_valid;
  assign m_axis_tdata = st.m_data;
  assign m_axis_tuser = st.m_sof;
  assign m_axis_tlast = st.m_line_end;
  assign busy = st.busy;
  assign frame_done = st.done;
  assign sof_early_err = st.sof_early;
  assign sof_late_err = st.sof_late;
  assign line_end_early_err = st.line_end_early;
  assign line_end_late_err = st.line_end_late;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  hold_when_off_a: assert property (!aclken |=> $stable(st))
    else $error("State changed while clock enable low");
  out_hold_a: assert property (m_axis_tvalid && !m_axis_tready && !sw_reset |=>
    m_axis_tvalid && $stable(m_axis_tdata))
    else $error("Output beat dropped under back-pressure");
  early_sof_a: assert property (acc && st.fsm == st_active && s_axis_tuser && !origin |=>
    m_axis_tvalid && m_axis_tuser && sof_early_err)
    else $error("Early frame start not forwarded at once");
  late_sof_a: assert property (acc && st.fsm == st_active && origin && !s_axis_tuser |=>
    st.fsm == st_drop_frame && !m_axis_tvalid && sof_late_err)
    else $error("Late frame start not handled");
  drop_frame_a: assert property (acc && st.fsm == st_drop_frame && !s_axis_tuser |=>
    !m_axis_tvalid)
    else $error("Beat passed while waiting for frame start");
  early_line_end_a: assert property (acc && st.fsm == st_active && !origin && !s_axis_tuser
    && s_axis_tlast && st.x != last_x |=> m_axis_tlast && line_end_early_err)
    else $error("Early line end not forwarded");
  late_line_end_a: assert property (acc && st.fsm == st_active && !origin && !s_axis_tuser
    && !s_axis_tlast && st.x == last_x |=> m_axis_tlast && st.fsm == st_drop_line)
    else $error("Late line end not closed at programmed place");
  sw_reset_a: assert property (aclken && sw_reset |=>
    st.fsm == st_idle && !m_axis_tvalid && !sof_late_err)
    else $error("Software reset ineffective");
  done_a: assert property (acc && !s_axis_tuser && st.fsm == st_active && !origin
    && st.y == last_y && st.x == last_x |=> frame_done && !busy)
    else $error("Frame completion not shown");
  ready_slot_a: assert property (s_axis_tready |-> !m_axis_tvalid)
    else $error("Ready while output slot full");

endmodule

`default_nettype wire

/* File: dv/video_sink_model.sv */
// Purpose: Downstream stream sink with random stalls
// Assumes: Shares clk and enable with the block
// Notes: Ready changes only just after a rising edge
`timescale 1ns/1ps
`default_nettype none

module video_sink_model (
  // Clock, enable and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic aclken,
  // Stream
  input wire logic tvalid,
  output logic tready
);
  logic [31:0] lfsr;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      lfsr <= 32'h1f3b;
      tready <= 1'b0;
    end
    else if (aclken)
    begin
      lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      tready <= !tvalid | lfsr[0] | lfsr[1];
    end
  end
endmodule

`default_nettype wire

/* File: dv/test_video_stream_frame_control.sv */
// Purpose: Self-checking bench for frame tracking and recovery
// Assumes: 4x2 frames programmed on the control inputs
// Notes: Expected beats queued by the source task
`include "video_frame_params.svh"
`timescale 1ns/1ps
`default_nettype none

module test_video_stream_frame_control;
  logic clk = 0, aclken = 1, rst_n = 0, sw_enable = 1, sw_reset = 0, ce_rand = 0;
  logic s_axis_tvalid = 0, s_axis_tuser = 0, s_axis_tlast = 0, s_axis_tready;
  logic [`VFC_DATA_WIDTH-1:0] s_axis_tdata = '0, m_axis_tdata;
  logic m_axis_tvalid, m_axis_tready, m_axis_tuser, m_axis_tlast;
  logic busy, frame_done, sof_early_err, sof_late_err, line_end_early_err, line_end_late_err;
  logic [3:0] errs;
  logic [31:0] rnd = 32'h38d7;
  logic [`VFC_DATA_WIDTH+1:0] q[$];
  logic [`VFC_DIM_WIDTH-1:0] cfg_width = 12'h004, cfg_height = 12'h002;
  int n_fail = 0, n_checks = 0;

  assign errs = {sof_early_err, sof_late_err, line_end_early_err, line_end_late_err};
  always #2 clk = ~clk;

  video_stream_frame_control u_dut (.clk(clk), .aclken(aclken), .rst_n(rst_n),
    .sw_enable(sw_enable), .sw_reset(sw_reset), .cfg_width(cfg_width), .cfg_height(cfg_height),
    .s_axis_tvalid(s_axis_tvalid), .s_axis_tready(s_axis_tready), .s_axis_tdata(s_axis_tdata),
    .s_axis_tuser(s_axis_tuser), .s_axis_tlast(s_axis_tlast), .m_axis_tvalid(m_axis_tvalid),
    .m_axis_tready(m_axis_tready), .m_axis_tdata(m_axis_tdata), .m_axis_tuser(m_axis_tuser),
    .m_axis_tlast(m_axis_tlast), .busy(busy), .frame_done(frame_done),
    .sof_early_err(sof_early_err), .sof_late_err(sof_late_err),
    .line_end_early_err(line_end_early_err), .line_end_late_err(line_end_late_err));

  video_sink_model u_sink (.clk(clk), .rst_n(rst_n), .aclken(aclken),
    .tvalid(m_axis_tvalid), .tready(m_axis_tready));

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic chk_beat(input logic [`VFC_DATA_WIDTH+1:0] e,
    input logic [`VFC_DATA_WIDTH+1:0] g);
    n_checks++;
    if (e !== g)
    begin
      n_fail++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk_stat(input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (e !== g)
    begin
      n_fail++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk_count(input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (e !== g)
    begin
      n_fail++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // One input beat, held until taken; em says whether an output beat is expected
  task automatic b(input logic tu, tl, em, eu, el);
    logic taken;
    rnd = xs(rnd);
    s_axis_tdata = rnd[`VFC_DATA_WIDTH-1:0];
    s_axis_tuser = tu;
    s_axis_tlast = tl;
    s_axis_tvalid = 1'b1;
    taken = 1'b0;
    while (!taken)
    begin
      @(negedge clk);
      taken = s_axis_tready && aclken && sw_enable && !sw_reset;
      @(posedge clk);
      #1;
      if (ce_rand)
      begin
        rnd = xs(rnd);
        aclken = rnd[3] | rnd[7];
      end
    end
    if (em) q.push_back({eu, el, s_axis_tdata});
  endtask

  task automatic frame(input int s);
    for (int i = s; i < 8; i++) b(i == 0, i % 4 == 3, 1, i == 0, i % 4 == 3);
  endtask

  task automatic line();
    for (int i = 0; i < 4; i++) b(0, i == 3, 1, 0, i == 3);
  endtask

  task automatic drain(input string name);
    s_axis_tvalid = 1'b0;
    ce_rand = 1'b0;
    @(posedge clk);
    #1;
    aclken = 1'b1;
    repeat (30) @(posedge clk);
    #1;
    chk_count(32'h0, q.size());
    $display("test %s done", name);
  endtask

  task automatic close_out();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(negedge clk)
  begin
    if (rst_n && aclken && sw_enable && !sw_reset && m_axis_tvalid && m_axis_tready)
    begin
      if (q.size() == 0)
        chk_count(32'h1, q.size());
      else
        chk_beat(q.pop_front(), {m_axis_tuser, m_axis_tlast, m_axis_tdata});
    end
  end

  initial
  begin
    #200000;
    n_fail++;
    close_out();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    chk_stat(8'h80, {s_axis_tready, m_axis_tvalid, busy, frame_done, errs});
    rst_n = 1;
    b(0, 0, 0, 0, 0);
    b(0, 1, 0, 0, 0);
    frame(0);
    drain("normal");
    chk_stat(8'h10, {2'h0, busy, frame_done, errs});
    b(1, 0, 1, 1, 0);
    b(0, 0, 1, 0, 0);
    drain("mid frame");
    chk_stat(8'h02, {6'h0, busy, frame_done});
    rst_n = 0;
    repeat (`VFC_RESET_HOLD_CYCLES) @(posedge clk);
    #1;
    chk_stat(8'h80, {s_axis_tready, m_axis_tvalid, busy, frame_done, errs});
    rst_n = 1;
    b(1, 0, 1, 1, 0);
    b(0, 1, 1, 0, 1);
    line();
    drain("early line end");
    chk_stat(8'h02, {4'h0, errs});
    b(1, 0, 1, 1, 0);
    b(0, 0, 1, 0, 0);
    frame(0);
    drain("early frame start");
    chk_stat(8'h0a, {4'h0, errs});
    b(1, 0, 1, 1, 0);
    b(0, 0, 1, 0, 0);
    b(0, 0, 1, 0, 0);
    b(0, 0, 1, 0, 1);
    b(0, 0, 0, 0, 0);
    b(0, 1, 0, 0, 0);
    line();
    drain("late line end");
    chk_stat(8'h0b, {4'h0, errs});
    b(0, 0, 0, 0, 0);
    b(0, 0, 0, 0, 0);
    frame(0);
    drain("late frame start");
    chk_stat(8'h0f, {4'h0, errs});
    b(1, 0, 1, 1, 0);
    aclken = 0;
    repeat (5) @(posedge clk);
    #1;
    chk_beat({2'b10, s_axis_tdata}, {m_axis_tvalid, s_axis_tready, m_axis_tdata});
    aclken = 1;
    b(0, 0, 1, 0, 0);
    sw_enable = 0;
    repeat (5) @(posedge clk);
    #1;
    chk_beat({2'b10, s_axis_tdata}, {m_axis_tvalid, s_axis_tready, m_axis_tdata});
    sw_enable = 1;
    ce_rand = 1;
    frame(2);
    repeat (3) frame(0);
    drain("enable stall");
    chk_stat(8'h01, {6'h0, busy, frame_done});
    sw_reset = 1;
    @(posedge clk);
    #1;
    sw_reset = 0;
    chk_stat(8'h40, {1'b0, s_axis_tready, m_axis_tvalid, frame_done, errs});
    frame(0);
    drain("software reset");
    close_out();
  end
endmodule

`default_nettype wire
